// file: inc/nvm_pkg.sv
package nvm_pkg;
   // register offsets (byte addresses of aligned words)
   localparam logic [11:0] OFS_COMMAND = 12'h000;
   localparam logic [11:0] OFS_PROTECT = 12'h004;
   localparam logic [11:0] OFS_STATE = 12'h008;
   localparam logic [11:0] OFS_IRQ_EN = 12'h00c;
   localparam logic [11:0] OFS_IRQ_FLAG = 12'h010;
   localparam logic [11:0] OFS_UNUSED = 12'h014;
   localparam logic [11:0] OFS_FUSE_LO = 12'h018;
   localparam logic [11:0] OFS_FUSE_HI = 12'h01c;
   localparam logic [11:0] OFS_ADDR_LO = 12'h020;
   localparam logic [11:0] OFS_ADDR_HI = 12'h024;
   localparam logic [11:0] OFS_KEY = 12'h028;
   localparam logic [11:0] OFS_CONFIG = 12'h02c;
   // field positions
   localparam int BIT_APP_GUARD = 0;
   localparam int BIT_BOOT_LOCK = 1;
   localparam int BIT_CODE_ACTIVE = 0;
   localparam int BIT_DATA_ACTIVE = 1;
   localparam int BIT_FAULT = 2;
   localparam int BIT_IDLE = 0;
   localparam int BIT_KEEP_DATA = 0;
   // change-guard key, value arbitrary
   localparam logic [7:0] SELF_PROGRAM_KEY = 8'h9d;
   localparam logic [2:0] KEY_WINDOW = 3'h4;
   // operation codes
   localparam logic [2:0] OP_NONE = 3'h0;
   localparam logic [2:0] OP_PAGE_PROGRAM = 3'h1;
   localparam logic [2:0] OP_PAGE_WIPE = 3'h2;
   localparam logic [2:0] OP_WIPE_THEN_PROGRAM = 3'h3;
   localparam logic [2:0] OP_BUFFER_FLUSH = 3'h4;
   localparam logic [2:0] OP_WHOLE_WIPE = 3'h5;
   localparam logic [2:0] OP_DATA_STORE_WIPE = 3'h6;
   localparam logic [2:0] OP_FUSE_PROGRAM = 3'h7;
   // data store occupies addresses at or above this base
   localparam logic [15:0] DATA_STORE_BASE = 16'h1400;
   localparam logic [15:0] BOOT_REGION_END = 16'h0200;
   // timing: flush is seven cycles, others a plain default
   localparam int CLK_MHZ = 100;
   localparam int FLUSH_CYCLES = 7;
   localparam int OP_TIME_US = 4;
   localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
   localparam int PAGE_WORDS = 64;
   localparam logic [7:0] RESET_VAL = 8'h00;
endpackage

// file: rtl/memory_programmer.sv
// How it works
// - three-bit code selects the operation
// - fuse program only from debug port
// - whole wipe spares data if fuse set
// - address picks code or data store
// - locked boot region reads as zero
// - boot lock set from boot only
// - boot lock blanks fetches after leaving boot
// - app guard blocks updates, reset clears
// - fault bit reports last operation error
// - busy bits per store during operation
// - idle flag held while data idle
// - level interrupt gated by enable bit
// - fuse value only stored and read back
// - address register holds last location
// - unguarded writes leave register unchanged
// - power-on timeout rejects commands, busy
// - buffer flush fills ones, stalls cpu
module memory_programmer #(
   parameter int POR_TIMEOUT_CYCLES = 10000
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // access source and cpu context
   input wire logic DEBUG_PORT_I,
   input wire logic EXEC_IN_BOOT_I,
   // memory read path through boot lock
   input wire logic [15:0] FETCH_ADDR_I,
   input wire logic [15:0] FETCH_DATA_I,
   output logic [15:0] FETCH_DATA_O,
   // cpu stall and interrupt
   output logic CPU_STALL_O,
   output logic IRQ_O
);
   import nvm_pkg::*;

   typedef enum {ST_IDLE, ST_FLUSH, ST_RUN} seq_e;

   // sequencer
   seq_e state, next_state;
   logic [15:0] op_count;
   // page buffer, filled with ones by a flush
   logic [7:0] page_buf [PAGE_WORDS];
   // command and protection state
   logic [2:0] command, active_op;
   logic app_guard, boot_lock, boot_lock_live, boot_pending;
   // status, interrupt and configuration
   logic fault, keep_data, irq_en, idle_flag, target_data, issued;
   // 16-bit data registers, written a byte at a time
   logic [15:0] fuse_value, target_loc;
   // key window and power-on timeout
   logic [2:0] key_count;
   logic [15:0] por_count;
   logic por_done;

   // apb decode
   wire wr = PSEL_I & PENABLE_I & PWRITE_I;
   wire rd = PSEL_I & PENABLE_I & ~PWRITE_I;
   wire [7:0] wbyte = PWDATA_I[7:0];
   wire key_open = key_count != 3'h0;

   // one select per mapped word
   wire sel_cmd = PADDR_I == OFS_COMMAND;
   wire sel_prot = PADDR_I == OFS_PROTECT;
   wire sel_en = PADDR_I == OFS_IRQ_EN;
   wire sel_flag = PADDR_I == OFS_IRQ_FLAG;
   wire sel_fuse_lo = PADDR_I == OFS_FUSE_LO;
   wire sel_fuse_hi = PADDR_I == OFS_FUSE_HI;
   wire sel_addr_lo = PADDR_I == OFS_ADDR_LO;
   wire sel_addr_hi = PADDR_I == OFS_ADDR_HI;
   wire sel_key = PADDR_I == OFS_KEY;
   wire sel_cfg = PADDR_I == OFS_CONFIG;
   wire sel_state = PADDR_I == OFS_STATE;
   wire sel_unused = PADDR_I == OFS_UNUSED;
   // anything else is unmapped and answers with an error
   wire mapped = sel_cmd | sel_prot | sel_en | sel_flag | sel_fuse_lo |
      sel_fuse_hi | sel_addr_lo | sel_addr_hi | sel_key | sel_cfg |
      sel_state | sel_unused;

   // busy per store; both read busy until power-on timeout ends
   wire busy = state != ST_IDLE;
   wire code_active = ~por_done | (busy & ~target_data);
   wire data_active = ~por_done | (busy & target_data);

   // command acceptance
   wire cmd_write = wr & sel_cmd & key_open;
   wire [2:0] op_req = wbyte[2:0];
   wire fuse_ok = DEBUG_PORT_I;
   wire op_target_data = target_loc >= DATA_STORE_BASE;
   wire page_op = op_req == OP_PAGE_PROGRAM | op_req == OP_PAGE_WIPE |
      op_req == OP_WIPE_THEN_PROGRAM;
   wire app_hit = page_op & ~op_target_data &
      (target_loc >= BOOT_REGION_END) & app_guard;
   wire boot_hit = page_op & ~op_target_data &
      (target_loc < BOOT_REGION_END) & boot_lock;
   wire refused = (op_req == OP_FUSE_PROGRAM & ~fuse_ok) | app_hit |
      boot_hit;
   wire start = cmd_write & ~busy & por_done & op_req != OP_NONE &
      ~refused;
   wire op_done = state == ST_RUN & op_count == 16'h0000;
   wire flush_done = state == ST_FLUSH & op_count == 16'h0000;
   // one-cycle start strobes, split by kind of operation
   wire start_flush = start & (op_req == OP_BUFFER_FLUSH);
   wire start_run = start & (op_req != OP_BUFFER_FLUSH);

   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_flush) begin
               next_state = ST_FLUSH;
            end else if (start_run) begin
               next_state = ST_RUN;
            end
         end
         ST_FLUSH: begin
            if (flush_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_RUN: begin
            if (op_done) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // operation timer; counts to zero then rests there
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         op_count <= 16'h0000;
      end else if (start_flush) begin
         op_count <= 16'(FLUSH_CYCLES - 1);
      end else if (start_run) begin
         op_count <= 16'(OP_CYCLES - 1);
      end else if (op_count != 16'h0000) begin
         op_count <= op_count - 16'h0001;
      end
   end

   // power-on timeout; long count kept as parameter
   wire por_last = por_count == 16'(POR_TIMEOUT_CYCLES - 1);
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         por_count <= 16'h0000;
      end else if (!por_done) begin
         por_count <= por_count + 16'h0001;
      end
   end

   // commands stay refused until the timeout has run out
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         por_done <= 1'b0;
      end else if (por_last) begin
         por_done <= 1'b1;
      end
   end

   // key window: counts down accesses after key
   wire key_write = wr & sel_key;
   wire key_good = wbyte == SELF_PROGRAM_KEY;
   wire bus_access = PSEL_I & PENABLE_I;
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         key_count <= 3'h0;
      end else if (key_write) begin
         key_count <= key_good ? KEY_WINDOW : 3'h0;
      end else if (bus_access && key_open) begin
         key_count <= key_count - 3'h1;
      end
   end

   // command field shows an accepted operation until it ends
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         command <= OP_NONE;
         active_op <= OP_NONE;
      end else if (start) begin
         command <= op_req;
         active_op <= op_req;
      end else if (op_done || flush_done) begin
         command <= OP_NONE;
      end
   end

   // fault reflects only the most recent command write
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         fault <= 1'b0;
      end else if (cmd_write) begin
         fault <= refused;
      end
   end

   // store picked at start; whole wipe spares data store if kept
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         target_data <= 1'b0;
      end else if (start) begin
         target_data <= page_op ? op_target_data :
            op_req == OP_DATA_STORE_WIPE |
            (op_req == OP_WHOLE_WIPE & ~keep_data);
      end
   end

   // remembers a started command; idle flag stays quiet before it
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         issued <= 1'b0;
      end else if (start) begin
         issued <= 1'b1;
      end
   end

   // protection writes need the key window open
   wire prot_write = wr & sel_prot & key_open;
   wire boot_set = prot_write & wbyte[BIT_BOOT_LOCK] & EXEC_IN_BOOT_I;

   // app guard: set only, cleared by reset
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         app_guard <= 1'b0;
      end else if (prot_write && wbyte[BIT_APP_GUARD]) begin
         app_guard <= 1'b1;
      end
   end

   // boot lock: set only from boot code, cleared by reset
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         boot_lock <= 1'b0;
         boot_pending <= 1'b0;
      end else if (boot_set) begin
         boot_lock <= 1'b1;
         boot_pending <= 1'b1;
      end
   end

   // fetch blanking bites only once execution has left boot code
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         boot_lock_live <= 1'b0;
      end else if (boot_pending && !EXEC_IN_BOOT_I) begin
         boot_lock_live <= 1'b1;
      end
   end

   // locked boot region reads and fetches as zero
   wire boot_fetch = FETCH_ADDR_I < BOOT_REGION_END;
   assign FETCH_DATA_O = boot_lock_live && boot_fetch ? 16'h0000 :
      FETCH_DATA_I;

   // fuse value, two independent byte halves
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         fuse_value <= 16'h0000;
      end else begin
         if (wr && sel_fuse_lo) fuse_value[7:0] <= wbyte;
         if (wr && sel_fuse_hi) fuse_value[15:8] <= wbyte;
      end
   end

   // target location, two independent byte halves
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         target_loc <= 16'h0000;
      end else begin
         if (wr && sel_addr_lo) target_loc[7:0] <= wbyte;
         if (wr && sel_addr_hi) target_loc[15:8] <= wbyte;
      end
   end

   // interrupt enable
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         irq_en <= 1'b0;
      end else if (wr && sel_en) begin
         irq_en <= wbyte[BIT_IDLE];
      end
   end

   // keep-data fuse stand-in
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         keep_data <= 1'b0;
      end else if (wr && sel_cfg) begin
         keep_data <= wbyte[BIT_KEEP_DATA];
      end
   end

   // idle flag; hold-set beats a clear while data store idle
   wire idle_set = issued & ~data_active;
   wire idle_clear = wr & sel_flag & wbyte[BIT_IDLE];
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         idle_flag <= 1'b0;
      end else if (idle_set) begin
         idle_flag <= 1'b1;
      end else if (idle_clear) begin
         idle_flag <= 1'b0;
      end
   end

   // page buffer flush to all ones, all words rewritten every flush cycle
   always_ff @(posedge SYS_CLK_I) begin
      if (state == ST_FLUSH) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            page_buf[i] <= 8'hff;
         end
      end
   end

   // cpu stalls for code-store work and buffer flush
   wire flush_stall = state == ST_FLUSH;
   wire code_stall = state == ST_RUN & ~target_data;
   assign CPU_STALL_O = flush_stall | code_stall;
   assign IRQ_O = irq_en & idle_flag;

   // register bytes, unused bits padded with zero
   wire [7:0] state_byte = {5'h00, fault, data_active, code_active};
   wire [7:0] cmd_byte = {5'h00, command};
   wire [7:0] prot_byte = {6'h00, boot_lock, app_guard};
   wire [7:0] en_byte = {7'h00, irq_en};
   wire [7:0] flag_byte = {7'h00, idle_flag};
   wire [7:0] cfg_byte = {7'h00, keep_data};

   // read mux; reserved and unused bits read zero
   wire [7:0] rmux =
      sel_cmd ? cmd_byte :
      sel_prot ? prot_byte :
      sel_state ? state_byte :
      sel_en ? en_byte :
      sel_flag ? flag_byte :
      sel_fuse_lo ? fuse_value[7:0] :
      sel_fuse_hi ? fuse_value[15:8] :
      sel_addr_lo ? target_loc[7:0] :
      sel_addr_hi ? target_loc[15:8] :
      sel_cfg ? cfg_byte : RESET_VAL;

   // registered read data, zero-wait answer
   wire rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (rd_setup) begin
         PRDATA_O <= {24'h000000, rmux};
      end
   end

   // zero-wait slave; unmapped offsets raise an error
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
endmodule

// file: tb/nvm_array_model.sv
module nvm_array_model (
   // read port of the memory array
   input wire logic [15:0] addr_i,
   output logic [15:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // never zero, so a blanked read cannot pass for stored data
   assign data_o = {addr_i[7:0], ~addr_i[15:8]} | 16'h0101;
endmodule

// file: tb/memory_programmer_assertions.sv
module memory_programmer_assertions (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // apb
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PSLVERR_O,
   // fetch path, stall, interrupt
   input wire logic [15:0] FETCH_ADDR_I,
   input wire logic [15:0] FETCH_DATA_I,
   input wire logic [15:0] FETCH_DATA_O,
   input wire logic CPU_STALL_O,
   input wire logic IRQ_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // access phase decode, aligned words up to the config word
   wire logic acc = PSEL_I & PENABLE_I;
   wire logic off_map = PADDR_I > 12'h02c || PADDR_I[1:0] != 2'b00;
   wire logic rd_setup = PSEL_I & !PENABLE_I & !PWRITE_I;
   // a flush holds the cpu for seven cycles at least
   sequence s_stall_min;
      CPU_STALL_O [*7];
   endsequence
   a_unmapped_err: assert property (acc && off_map |-> PSLVERR_O)
      else $error("no error on unmapped access");
   a_mapped_ok: assert property (acc && !off_map |-> !PSLVERR_O)
      else $error("error on mapped access");
   a_upper_zero: assert property (PRDATA_O[31:8] == 24'h0)
      else $error("unused read bits not zero");
   a_rdata_holds: assert property (!rd_setup |=> $stable(PRDATA_O))
      else $error("read data moved without a read");
   a_fetch_pass: assert property (FETCH_ADDR_I >= 16'h0200
      |-> FETCH_DATA_O == FETCH_DATA_I) else $error("fetch altered");
   a_fetch_blank: assert property (FETCH_DATA_O == FETCH_DATA_I
      || FETCH_DATA_O == 16'h0) else $error("fetch neither data nor zero");
   a_stall_min: assert property ($rose(CPU_STALL_O) |-> s_stall_min)
      else $error("stall too short");
   a_stall_ends: assert property ($rose(CPU_STALL_O)
      |-> ##[7:401] !CPU_STALL_O) else $error("stall too long");
   a_quiet_start: assert property ($rose(RST_N_I)
      |-> !IRQ_O && !CPU_STALL_O) else $error("busy out of reset");
endmodule

bind memory_programmer memory_programmer_assertions i_chk (.SYS_CLK_I,
   .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O,
   .PSLVERR_O, .FETCH_ADDR_I, .FETCH_DATA_I, .FETCH_DATA_O,
   .CPU_STALL_O, .IRQ_O);

// file: tb/test_nvm_command_register_interface.sv
module test_nvm_command_register_interface;
   import nvm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, dbg = 0, boot = 0;
   logic pready, pslverr, stall, irq, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] faddr = 0, fdata, fout, a;
   logic [2:0] ops [4] = '{OP_PAGE_PROGRAM, OP_PAGE_WIPE,
      OP_WIPE_THEN_PROGRAM, OP_DATA_STORE_WIPE};
   int error_cnt = 0, samples_checked = 0, scnt = 0, seed = 32'h0729c814;
   memory_programmer #(.POR_TIMEOUT_CYCLES(20)) i_dut (.SYS_CLK_I(clk),
      .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .DEBUG_PORT_I(dbg),
      .EXEC_IN_BOOT_I(boot), .FETCH_ADDR_I(faddr), .FETCH_DATA_I(fdata),
      .FETCH_DATA_O(fout), .CPU_STALL_O(stall), .IRQ_O(irq));
   nvm_array_model i_mem (.addr_i(faddr), .data_o(fdata));
   // clock and stall counter
   always #5 clk = ~clk;
   always @(posedge clk) if (stall) scnt++;
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // setup, access until pready, then one idle cycle
   task automatic xfer(input logic w, input logic [11:0] ad,
         input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwr <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      while (pready !== 1'b1 && n++ < 20) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [11:0] ad, input logic [31:0] e);
      xfer(0, ad, 0);
      cmp(rd, e);
   endtask
   task automatic guard(input logic [11:0] ad, input logic [31:0] d);
      xfer(1, OFS_KEY, {24'h0, SELF_PROGRAM_KEY});
      xfer(1, ad, d);
   endtask
   task automatic idle;
      int n;
      n = 0;
      do xfer(0, OFS_STATE, 0); while (rd[1:0] !== 2'b00 && n++ < 300);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   // busy bit expected for an operation at an address
   function automatic logic [31:0] busy_of(logic [2:0] op, logic [15:0] ad);
      if (op == OP_DATA_STORE_WIPE || ad >= DATA_STORE_BASE) return 2;
      return 1;
   endfunction
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // watchdog, several times the expected run
   initial begin
      #300us;
      error_cnt++;
      end_sim;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      rchk(OFS_STATE, 3);
      guard(OFS_COMMAND, OP_DATA_STORE_WIPE);
      repeat (25) @(posedge clk);
      for (int i = 0; i < 10; i++) rchk(12'(i * 4), 0);
      xfer(1, OFS_COMMAND, 6);
      rchk(OFS_COMMAND, 0);
      xfer(1, OFS_UNUSED, 32'hff);
      xfer(1, 12'h030, 32'hff);
      cmp(err, 1);
      rchk(OFS_UNUSED, 0);
      xfer(1, OFS_FUSE_HI, 32'hffff_ff5a);
      rchk(OFS_FUSE_HI, 32'h5a);
      done("access");
      scnt = 0;
      guard(OFS_COMMAND, OP_BUFFER_FLUSH);
      repeat (10) @(posedge clk);
      cmp(scnt, FLUSH_CYCLES);
      for (int i = 0; i < 8; i++) begin
         a = 16'($random(seed));
         faddr <= a;
         xfer(1, OFS_ADDR_LO, a[7:0]);
         xfer(1, OFS_ADDR_HI, a[15:8]);
         guard(OFS_COMMAND, ops[i % 4]);
         cmp(stall, busy_of(ops[i % 4], a) == 1);
         xfer(1, OFS_IRQ_FLAG, 1);
         xfer(1, OFS_IRQ_EN, 1);
         cmp(irq, busy_of(ops[i % 4], a) == 1);
         rchk(OFS_STATE, busy_of(ops[i % 4], a));
         idle;
         cmp(irq, 1);
         xfer(1, OFS_IRQ_EN, 0);
         cmp(irq, 0);
         rchk(OFS_ADDR_HI, a[15:8]);
      end
      xfer(1, OFS_IRQ_FLAG, 1);
      rchk(OFS_IRQ_FLAG, 1);
      for (int k = 0; k < 2; k++) begin
         xfer(1, OFS_CONFIG, k);
         guard(OFS_COMMAND, OP_WHOLE_WIPE);
         xfer(0, OFS_STATE, 0);
         cmp(rd[1], k == 0);
         idle;
      end
      guard(OFS_COMMAND, OP_FUSE_PROGRAM);
      rchk(OFS_STATE, 4);
      dbg <= 1;
      guard(OFS_COMMAND, OP_FUSE_PROGRAM);
      xfer(0, OFS_STATE, 0);
      cmp(rd[2], 0);
      idle;
      dbg <= 0;
      done("ops");
      xfer(1, OFS_PROTECT, 1);
      rchk(OFS_PROTECT, 0);
      guard(OFS_PROTECT, 1);
      xfer(1, OFS_ADDR_HI, 8);
      guard(OFS_COMMAND, OP_PAGE_PROGRAM);
      rchk(OFS_STATE, 4);
      guard(OFS_PROTECT, 2);
      rchk(OFS_PROTECT, 1);
      boot <= 1;
      guard(OFS_PROTECT, 3);
      rchk(OFS_PROTECT, 3);
      faddr <= 16'h0100;
      @(posedge clk);
      cmp(fout, fdata);
      boot <= 0;
      repeat (2) @(posedge clk);
      cmp(fout, 0);
      rst_n <= 0;
      repeat (3) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      rchk(OFS_PROTECT, 0);
      rchk(OFS_STATE, 3);
      done("guard");
      end_sim;
   end
endmodule
